// File: adc_seq_pkg.sv
package adc_seq_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;

  // control word layout
  localparam int CTRL_BITS = 12;
  localparam int BIT_WRITE = 11;
  localparam int BIT_SEQ_HI = 10;
  localparam int BIT_CH_HI = 7;
  localparam int BIT_CH_LO = 6;
  localparam int BIT_PM_HI = 5;
  localparam int BIT_PM_LO = 4;
  localparam int BIT_SEQ_LO = 3;
  localparam int BIT_RANGE = 1;
  localparam int BIT_CODING = 0;
  localparam logic [11:0] CTRL_RESET = 12'h031;

  // result word layout
  localparam int WORD_BITS = 16;
  localparam int RESULT_BITS = 12;
  localparam int LSB_DIVISOR = 4096;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
  localparam logic [1:0] CH_FIRST = 2'h0;

  // serial clock falling-edge positions in a frame
  localparam logic [4:0] FALL_CTRL_LAST = 5'h0c;
  localparam logic [4:0] FALL_HOLD_END = 5'h0e;
  localparam logic [4:0] FALL_WORD_END = 5'h10;

  // timing
  localparam longint CLK_FREQ_HZ = 125_000_000;
  localparam longint SCLK_MAX_HZ = 20_000_000;
  localparam longint CONV_MIN_NS = 800;
  localparam int CONV_MIN_CYC = int'((CONV_MIN_NS * CLK_FREQ_HZ + 64'd999_999_999)
                                      / 64'd1_000_000_000);

  typedef enum logic {
    FRAME_IDLE = 1'b0,
    FRAME_RUN = 1'b1
  } frame_state_e;

endpackage

// File: link_if.sv
`timescale 1ns/100ps
interface link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic din;
  logic comp;
  modport front (output sclk_rise, output sclk_fall, output cs_fall, output cs_rise,
                 output din, output comp);
  modport core (input sclk_rise, input sclk_fall, input cs_fall, input cs_rise,
                input din, input comp);
endinterface

// File: link_front.sv
`timescale 1ns/100ps
module link_front (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic comp_i,
  link_if.front lk
);
  logic sclk_m, sclk_s, sclk_d;
  logic cs_m, cs_s, cs_d;
  logic din_m, din_s;
  logic comp_m, comp_s;

  // two-stage synchronisers, third stage for edges
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      din_m <= 1'b0;
      din_s <= 1'b0;
      comp_m <= 1'b0;
      comp_s <= 1'b0;
    end else begin
      sclk_m <= sclk_i;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      cs_m <= cs_n_i;
      cs_s <= cs_m;
      cs_d <= cs_s;
      din_m <= din_i;
      din_s <= din_m;
      comp_m <= comp_i;
      comp_s <= comp_m;
    end
  end

  assign lk.sclk_rise = sclk_s & ~sclk_d;
  assign lk.sclk_fall = ~sclk_s & sclk_d;
  assign lk.cs_fall = ~cs_s & cs_d;
  assign lk.cs_rise = cs_s & ~cs_d;
  assign lk.din = din_s;
  assign lk.comp = comp_s;
endmodule

// File: adc_channel_sequencer.sv
`timescale 1ns/100ps
module adc_channel_sequencer
  import adc_seq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic comp_i,
  output logic [11:0] dac_code_o,
  output logic [1:0] mux_sel_o,
  output logic range_o,
  output logic hold_o
);

  function automatic logic [15:0] format_word(input logic [1:0] chan,
                                              input logic [11:0] code,
                                              input logic coding);
    logic [11:0] shaped;
    shaped = coding ? code : {~code[11], code[10:0]};
    return {2'b00, chan, shaped};
  endfunction

  function automatic logic [11:0] sar_step(input logic [11:0] cur,
                                           input logic [3:0] idx,
                                           input logic keep);
    logic [11:0] nxt;
    nxt = cur;
    nxt[idx] = keep;
    if (idx != 4'h0) begin
      nxt[idx - 4'h1] = 1'b1;
    end
    return nxt;
  endfunction

  link_if lk();

  link_front u_front (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .comp_i(comp_i),
    .lk(lk.front)
  );

  frame_state_e frame_state;
  logic [4:0] fall_cnt;
  logic [11:0] shift_in;
  logic [11:0] ctrl;
  logic seq_active;
  logic [1:0] final_chan;
  logic [1:0] next_chan;
  logic [1:0] conv_chan;
  logic conv_coding;
  logic [11:0] sar;
  logic [15:0] result_word;
  logic [7:0] conv_age;

  // frame decode
  wire frame_run = (frame_state == FRAME_RUN);
  wire fall_run = frame_run & lk.sclk_fall & (fall_cnt != FALL_WORD_END);
  wire [4:0] fall_next = fall_cnt + 5'h01;
  wire [11:0] link_word = {shift_in[10:0], lk.din};
  wire link_last_bit = fall_run & (fall_next == FALL_CTRL_LAST);
  wire link_wr = link_last_bit & link_word[BIT_WRITE];
  wire word_done = fall_run & (fall_next == FALL_WORD_END);
  wire sar_dec = frame_run & lk.sclk_rise & (fall_cnt != 5'h00)
                 & (fall_cnt <= FALL_CTRL_LAST);
  wire [3:0] sar_idx = 4'(FALL_CTRL_LAST - fall_cnt);
  wire [15:0] word_now = format_word(conv_chan, sar, conv_coding);
  wire [3:0] out_idx = 4'(5'h0f - fall_next);
  wire out_bit = (fall_next < FALL_WORD_END) ? word_now[out_idx] : 1'b0;

  // apb decode
  wire apb_setup = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i;
  wire hit_ctrl = (paddr_i == ADDR_CTRL);
  wire hit_status = (paddr_i == ADDR_STATUS);
  wire hit_result = (paddr_i == ADDR_RESULT);
  wire hit_any = hit_ctrl | hit_status | hit_result;
  wire apb_ctrl_wr = apb_access & pwrite_i & hit_ctrl;
  wire [31:0] status_word = {24'h000000, frame_run, seq_active, final_chan, next_chan,
                             conv_chan};
  wire [31:0] rd_mux = hit_ctrl ? {20'h00000, ctrl} :
                       hit_status ? status_word :
                       hit_result ? {16'h0000, result_word} : 32'h00000000;

  // control write, link wins over apb
  wire ctrl_wr = link_wr | apb_ctrl_wr;
  wire [11:0] ctrl_new = link_wr ? link_word : pwdata_i[11:0];
  wire [1:0] new_chan = {ctrl_new[BIT_CH_HI], ctrl_new[BIT_CH_LO]};
  wire seq_start = ctrl_new[BIT_SEQ_HI] & ctrl_new[BIT_SEQ_LO];
  wire seq_keep = ctrl_new[BIT_SEQ_HI] & ~ctrl_new[BIT_SEQ_LO];
  wire [1:0] seq_after = (next_chan == final_chan) ? CH_FIRST : next_chan + 2'h1;

  assign pready_o = 1'b1;
  assign pslverr_o = apb_access & ~hit_any;
  assign mux_sel_o = conv_chan;
  assign dac_code_o = sar;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prdata_o <= 32'h00000000;
    end else if (apb_setup) begin
      prdata_o <= rd_mux;
    end
  end

  // frame sequencing on serial clock edges
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      frame_state <= FRAME_IDLE;
      fall_cnt <= 5'h00;
      shift_in <= 12'h000;
    end else if (lk.cs_fall) begin
      frame_state <= FRAME_RUN;
      fall_cnt <= 5'h00;
    end else if (lk.cs_rise) begin
      frame_state <= FRAME_IDLE;
    end else if (fall_run) begin
      fall_cnt <= fall_next;
      if (fall_cnt < FALL_CTRL_LAST) begin
        shift_in <= link_word;
      end
    end
  end

  // serial data out and track/hold
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
      hold_o <= 1'b0;
    end else if (lk.cs_fall) begin
      dout_o <= 1'b0;
      dout_oe_o <= 1'b1;
      hold_o <= 1'b1;
    end else if (lk.cs_rise) begin
      dout_oe_o <= 1'b0;
      hold_o <= 1'b0;
    end else if (fall_run) begin
      dout_o <= out_bit;
      if (fall_next == FALL_HOLD_END) begin
        hold_o <= 1'b0;
      end
    end
  end

  // successive approximation clocked by serial clock rises
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sar <= 12'h000;
    end else if (lk.cs_fall) begin
      sar <= SAR_FIRST_TRIAL;
    end else if (sar_dec) begin
      sar <= sar_step(sar, sar_idx, lk.comp);
    end
  end

  // conversion settings latched at chip-select fall
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      conv_chan <= CH_FIRST;
      conv_coding <= CTRL_RESET[BIT_CODING];
      range_o <= CTRL_RESET[BIT_RANGE];
    end else if (lk.cs_fall) begin
      conv_chan <= next_chan;
      conv_coding <= ctrl[BIT_CODING];
      range_o <= ctrl[BIT_RANGE];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      result_word <= 16'h0000;
    end else if (word_done) begin
      result_word <= word_now;
    end
  end

  // control register, written by link only when write bit set, by apb on any write to ADDR_CTRL
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= ctrl_new;
    end
  end

  // channel sequencer
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      seq_active <= 1'b0;
      final_chan <= CH_FIRST;
      next_chan <= CH_FIRST;
    end else begin
      if (lk.cs_fall && seq_active) begin
        next_chan <= seq_after;
      end
      if (ctrl_wr) begin
        if (seq_start) begin
          seq_active <= 1'b1;
          final_chan <= new_chan;
          next_chan <= CH_FIRST;
        end else if (!(seq_keep && seq_active)) begin
          seq_active <= 1'b0;
          next_chan <= new_chan;
        end
      end
    end
  end

  // cycles since conversion start, only for checking
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      conv_age <= 8'h00;
    end else if (lk.cs_fall) begin
      conv_age <= 8'h00;
    end else if (conv_age != 8'hff) begin
      conv_age <= conv_age + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  sequence s_conv_start;
    lk.cs_fall && !ctrl_wr;
  endsequence

  sequence s_settle_chan;
    ##1 (mux_sel_o == $past(next_chan));
  endsequence

  property p_mux_follows;
    s_conv_start |-> s_settle_chan;
  endproperty
  a_mux_follows: assert property (p_mux_follows)
    else $error("mux select not taken from next channel");

  property p_seq_start;
    ctrl_wr && seq_start |=> seq_active && next_chan == CH_FIRST
                             && final_chan == $past(new_chan);
  endproperty
  a_seq_start: assert property (p_seq_start)
    else $error("sequence start did not arm channel 0");

  property p_seq_advance;
    s_conv_start and (seq_active && next_chan != final_chan)
      |=> next_chan == $past(next_chan) + 2'h1;
  endproperty
  a_seq_advance: assert property (p_seq_advance)
    else $error("sequencer did not step to next channel");

  property p_no_write_hold;
    link_last_bit && !link_word[BIT_WRITE] && !apb_ctrl_wr |=> $stable(ctrl);
  endproperty
  a_no_write_hold: assert property (p_no_write_hold)
    else $error("control changed without write bit");

  property p_seq_keep;
    ctrl_wr && seq_keep && seq_active |=> seq_active && $stable(final_chan)
                                          && ctrl == $past(ctrl_new);
  endproperty
  a_seq_keep: assert property (p_seq_keep)
    else $error("continue write disturbed the sequence");

  property p_seq_end;
    ctrl_wr && !seq_keep && !seq_start |=> !seq_active && next_chan == $past(new_chan);
  endproperty
  a_seq_end: assert property (p_seq_end)
    else $error("terminating write did not end the sequence");

  property p_seq_wrap;
    s_conv_start and (seq_active && next_chan == final_chan) |=> next_chan == CH_FIRST;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap)
    else $error("sequence did not wrap to channel 0");

  property p_word_frame;
    word_done |=> result_word[15:14] == 2'b00 && result_word[13:12] == $past(conv_chan);
  endproperty
  a_word_frame: assert property (p_word_frame)
    else $error("result word header wrong");

  property p_coding;
    word_done |=> result_word[11] == ($past(sar[11]) ^ !$past(conv_coding))
                  && result_word[10:0] == $past(sar[10:0]);
  endproperty
  a_coding: assert property (p_coding)
    else $error("result coding wrong");

  property p_range;
    lk.cs_fall |=> range_o == $past(ctrl[BIT_RANGE]) ##1 $stable(range_o);
  endproperty
  a_range: assert property (p_range)
    else $error("range not latched at conversion start");

  property p_sar_last;
    sar_dec && sar_idx == 4'h0 |=> sar[0] == $past(lk.comp) ##1 $stable(sar[0]);
  endproperty
  a_sar_last: assert property (p_sar_last)
    else $error("last approximation step wrong");

  sequence s_bit_clocked;
    fall_run ##1 (fall_cnt == $past(fall_cnt) + 5'h01);
  endsequence

  property p_sclk_count;
    fall_run && !lk.cs_fall |-> s_bit_clocked;
  endproperty
  a_sclk_count: assert property (p_sclk_count)
    else $error("serial clock fall not counted");

  property p_start_state;
    lk.cs_fall |=> frame_run && fall_cnt == 5'h00 && dout_oe_o && hold_o
                   && sar == SAR_FIRST_TRIAL;
  endproperty
  a_start_state: assert property (p_start_state)
    else $error("conversion start not taken");

  property p_conv_time;
    word_done |-> conv_age >= 8'(CONV_MIN_CYC - 1);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("conversion finished faster than minimum time");

  property p_coding_next;
    ctrl_wr && !lk.cs_fall |=> $stable(conv_coding);
  endproperty
  a_coding_next: assert property (p_coding_next)
    else $error("coding changed within a conversion");

  property p_twos_mid;
    word_done && !conv_coding |=> result_word[11:0] == 12'($past(sar) - SAR_FIRST_TRIAL);
  endproperty
  a_twos_mid: assert property (p_twos_mid)
    else $error("twos complement not offset from mid-scale");

endmodule

// File: acs_host_model.sv
`timescale 1ns/100ps
module acs_host_model (
  input wire logic clk_sys_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i,
  output logic [15:0] word_o,
  output logic word_valid_o
);
  logic busy;

  initial begin
    busy = 1'b0;
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    word_o = 16'h0000;
    word_valid_o = 1'b0;
  end

  // idle data line keeps moving so no stale bit reads as valid
  always @(posedge clk_sys_i) begin
    if (!busy) begin
      din_o <= ~din_o;
    end
  end

  // one frame of the given number of serial clock falls
  task automatic xfer(input logic [11:0] ctrl, input int falls);
    logic [15:0] got;
    got = 16'h0000;
    @(posedge clk_sys_i);
    busy <= 1'b1;
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    din_o <= ctrl[11];
    repeat (5) @(posedge clk_sys_i);
    for (int k = 1; k <= falls; k++) begin
      sclk_o <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      got = {got[14:0], dout_i};
      sclk_o <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      din_o <= (k < 12) ? ctrl[11-k] : ~din_o;
    end
    repeat (5) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    if (falls == 16) begin
      word_o <= got;
      word_valid_o <= 1'b1;
    end
    @(posedge clk_sys_i);
    word_valid_o <= 1'b0;
    busy <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
  endtask
endmodule

// File: adc_channel_sequencer_tb_top.sv
`timescale 1ns/100ps
module adc_channel_sequencer_tb_top
  import adc_seq_pkg::*;
;
  logic clk_sys_i, srst_i, psel_i, penable_i, pwrite_i, comp_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, er, sclk, cs_n, din, dout_o, dout_oe_o, range_o, hold_o;
  logic [11:0] dac_code_o, last_ctrl;
  logic [1:0] mux_sel_o, fin, nxt;
  logic [15:0] word, last_word;
  logic word_valid, act, cod, rng;
  logic [12:0] ain [4];
  logic [14:0] thr;
  logic [31:0] seed;
  logic [15:0] exp_q [$];
  int failures, num_checks;

  adc_channel_sequencer i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .comp_i(comp_i),
    .dac_code_o(dac_code_o), .mux_sel_o(mux_sel_o), .range_o(range_o), .hold_o(hold_o));

  acs_host_model i_host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dout_i(dout_oe_o ? dout_o : ~dout_o), .word_o(word), .word_valid_o(word_valid));

  // comparator: input in half-lsb units with range set, quarter-lsb units with range clear, against the trial code
  assign thr = range_o ? {2'b00, dac_code_o, 1'b0} : {1'b0, dac_code_o, 2'b00};
  always @(posedge clk_sys_i) begin
    comp_i <= ({2'b00, ain[mux_sel_o]} >= thr);
  end

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [11:0] mk(input logic w, input logic [1:0] sq,
                                     input logic [1:0] ch, input logic rg, input logic cd);
    logic [31:0] r;
    r = rnd();
    return {w, sq[1], r[1:0], ch, 2'b11, sq[0], r[2], rg, cd};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    bit done;
    done = 0;
    rdat = 32'h0;
    err = 1'b0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge clk_sys_i);
      if (pready_o === 1'b1) begin
        rdat = prdata_o;
        err = pslverr_o;
        done = 1;
      end
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (!done) begin
      failures++;
      $display("mismatch at %0t: bus wait ran out", $time);
      test_done();
    end
  endtask

  // runs one frame and keeps the expected sequencer state
  task automatic frame(input logic [11:0] ctrl, input int falls);
    logic [1:0] ch;
    logic [11:0] c;
    logic [31:0] t;
    for (int i = 0; i < 4; i++) begin
      t = rnd();
      ain[i] = t[12:0];
    end
    ch = nxt;
    c = rng ? ain[ch][12:1] : {1'b0, ain[ch][12:2]};
    if (!cod) c[11] = ~c[11];
    if (falls == 16) begin
      exp_q.push_back({2'b00, ch, c});
      last_word = {2'b00, ch, c};
    end
    i_host.xfer(ctrl, falls);
    check({30'h0, dout_oe_o, hold_o}, 32'h0);
    if (falls >= 12 && ctrl[BIT_WRITE]) begin
      last_ctrl = ctrl;
      cod = ctrl[BIT_CODING];
      rng = ctrl[BIT_RANGE];
      if (ctrl[BIT_SEQ_HI] && ctrl[BIT_SEQ_LO]) begin
        act = 1'b1;
        fin = ctrl[BIT_CH_HI:BIT_CH_LO];
        nxt = CH_FIRST;
      end else if (ctrl[BIT_SEQ_HI] && act) begin
        nxt = (ch == fin) ? CH_FIRST : ch + 2'd1;
      end else begin
        act = 1'b0;
        nxt = ctrl[BIT_CH_HI:BIT_CH_LO];
      end
    end else if (act) begin
      nxt = (ch == fin) ? CH_FIRST : ch + 2'd1;
    end
  endtask

  always @(posedge clk_sys_i) begin
    if (word_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("mismatch at %0t: word without a note", $time);
      end else begin
        check({16'h0, word}, {16'h0, exp_q.pop_front()});
      end
    end
  end

  initial begin
    #800000;
    failures++;
    $display("mismatch at %0t: run too long", $time);
    test_done();
  end

  initial begin
    logic [2:0] v;
    seed = 32'hcb0c4ecd;
    srst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    comp_i = 1'b0;
    for (int i = 0; i < 4; i++) ain[i] = 13'h0000;
    {act, fin, nxt, cod, rng} = 7'h02;
    last_word = 16'h0000;
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check(rd, {20'h0, CTRL_RESET});
    apb(1'b1, 8'h0c, rnd(), rd, er);
    check({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hffffffff, rd, er);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    check(rd & 32'hcc, 32'h0);
    for (int n = 0; n < 8; n++) begin
      v = n[2:0];
      frame(mk(1'b1, {1'b0, v[2]}, v[1:0], v[0], v[1]), 16);
    end
    frame(mk(1'b1, 2'b11, 2'd3, 1'b1, 1'b0), 8);
    apb(1'b0, ADDR_RESULT, 32'h0, rd, er);
    check(rd, {16'h0, last_word});
    frame(mk(1'b1, 2'b11, 2'd2, 1'b1, 1'b1), 16);
    for (int n = 0; n < 5; n++) frame(mk(1'b0, 2'b11, 2'd0, 1'b0, 1'b0), 16);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    check(rd & 32'hfc, {24'h0, 1'b0, act, fin, nxt, 2'b00});
    frame(mk(1'b1, 2'b10, 2'd3, 1'b0, 1'b0), 16);
    for (int n = 0; n < 2; n++) frame(mk(1'b0, 2'b00, 2'd1, 1'b1, 1'b1), 16);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check({20'h0, rd[11:0] & 12'h4fb}, {20'h0, last_ctrl & 12'h4fb});
    frame(mk(1'b1, 2'b01, 2'd3, 1'b1, 1'b1), 16);
    for (int n = 0; n < 2; n++) frame(mk(1'b0, 2'b11, 2'd0, 1'b0, 1'b0), 16);
    last_ctrl = mk(1'b1, 2'b10, 2'd1, 1'b1, 1'b0);
    apb(1'b1, ADDR_CTRL, {20'h0, last_ctrl}, rd, er);
    check({31'h0, er}, 32'h0);
    {act, nxt, cod, rng} = 5'b00101;
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check(rd, {20'h0, last_ctrl});
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    check(rd & 32'h4c, {24'h0, 1'b0, act, 2'b00, nxt, 2'b00});
    frame(mk(1'b0, 2'b11, 2'd0, 1'b0, 1'b0), 16);
    for (int i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge clk_sys_i);
    if (exp_q.size() != 0) begin
      failures++;
      $display("mismatch at %0t: words missing", $time);
    end
    test_done();
  end
endmodule
